// >>> include/gcm_pkg.sv
// constants and carrier types for the group control word mapper
package gcm_pkg;
   localparam int IDX_W = 4;
   localparam int ADR_W = 8;
   // register byte addresses
   localparam logic [7:0] ADDR_CFG  = 8'h00;
   localparam logic [7:0] ADDR_CNT  = 8'h04;
   localparam logic [7:0] ADDR_SEL  = 8'h08;
   localparam logic [7:0] ADDR_TBL  = 8'h0C;
   // configuration fields and reset value
   localparam int CFG_RING_BIT = 0;
   localparam int CFG_RED_BIT  = 1;
   localparam int CFG_ACT_BIT  = 2;
   localparam int CFG_SIG_BIT  = 3;
   localparam logic [3:0] CFG_RST = 4'h8;
   // reduced profile keeps only these control bits
   localparam logic [15:0] RED_KEEP = 16'hFF22;
   // user part of the signal words
   localparam int SIG_USER_LSB = 12;
   // field bus control word positions
   localparam int CW_ACCEPT = 0;
   localparam int CW_OPSET  = 1;
   localparam int CW_ZERO   = 2;
   localparam int CW_ABSREL = 3;
   localparam int CW_IMMED  = 4;
   localparam int CW_CLRERR = 5;
   localparam int CW_JOG0   = 6;
   localparam int CW_JOG1   = 7;
   localparam int CW_OPM0   = 8;
   localparam int CW_OPM1   = 9;
   localparam int CW_SYNC   = 12;
   localparam int CW_HALT   = 13;
   localparam int CW_ENA    = 14;
   localparam int CW_ON     = 15;
   // signal control word positions
   localparam int SC_ACCEPT = 0;
   localparam int SC_ZERO   = 1;
   localparam int SC_ABSREL = 2;
   localparam int SC_IMMED  = 3;
   localparam int SC_CLRERR = 4;
   localparam int SC_JOG0   = 5;
   localparam int SC_JOG1   = 6;
   localparam int SC_PENTER = 7;
   localparam int SC_PEXIT  = 8;
   // master control word position of the sync toggle
   localparam int MC_SYNC   = 10;
   // field bus status word positions
   localparam int FS_OPACK  = 1;
   localparam int FS_INREF  = 2;
   localparam int FS_STILL  = 3;
   localparam int FS_REACH  = 4;
   localparam int FS_CHG    = 5;
   localparam int FS_PROC   = 7;
   localparam int FS_CMDACK = 10;
   // drive status word positions
   localparam int DS_PROC   = 3;
   localparam int DS_CHG    = 5;

   // control word leads each slave's command block
   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      logic [15:0]      ctrl;
      logic [15:0]      sig_ctrl;
      logic             sig_on;
      logic [31:0]      mcw;
      logic [31:0]      cmd;
   } gcm_up_t;

   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      logic [31:0]      mcw;
      logic [15:0]      scw;
      logic             scw_on;
      logic [31:0]      cmd;
   } gcm_dn_t;

   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      logic [31:0]      dsw;
      logic [15:0]      ssw;
      logic [31:0]      act;
   } gcm_gs_t;

   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      logic [15:0]      stat;
      logic [15:0]      sig_stat;
      logic             sig_on;
      logic [31:0]      act;
   } gcm_fs_t;
endpackage

// >>> src/gcm_ctrl_map.sv
// control word split into master and signal control words
`timescale 1ns/1ps
`default_nettype none
module gcm_ctrl_map (
   input  wire logic [15:0] i_ctrl,
   input  wire logic [15:0] i_sig,
   input  wire logic        i_sig_on,
   input  wire logic [31:0] i_mcw,
   input  wire logic        i_ring,
   input  wire logic        i_reduced,
   input  wire logic        i_active,
   output logic      [31:0] o_mcw,
   output logic      [15:0] o_scw
);
   logic [15:0] cw;
   logic [15:0] usr;

   always_comb begin
      cw    = i_reduced ? (i_ctrl & gcm_pkg::RED_KEEP) : i_ctrl;
      usr   = i_sig_on ? i_sig : 16'h0000;
      o_mcw = 32'h0000_0000;
      o_scw = 16'h0000;
      if (i_ring) begin
         // ring links: no translation, signal word free
         o_mcw = i_mcw;
         o_scw = usr;
      end else begin
         o_scw[gcm_pkg::SC_ACCEPT] = cw[gcm_pkg::CW_ACCEPT];
         // level form: enter while set, exit while clear
         o_scw[gcm_pkg::SC_PENTER] = cw[gcm_pkg::CW_OPSET];
         o_scw[gcm_pkg::SC_PEXIT]  = ~cw[gcm_pkg::CW_OPSET];
         o_scw[gcm_pkg::SC_ZERO]   = cw[gcm_pkg::CW_ZERO];
         o_scw[gcm_pkg::SC_ABSREL] = cw[gcm_pkg::CW_ABSREL];
         o_scw[gcm_pkg::SC_IMMED]  = cw[gcm_pkg::CW_IMMED];
         o_scw[gcm_pkg::SC_JOG0]   = cw[gcm_pkg::CW_JOG0];
         o_scw[gcm_pkg::SC_JOG1]   = cw[gcm_pkg::CW_JOG1];
         o_scw[gcm_pkg::SC_CLRERR] = cw[gcm_pkg::CW_CLRERR];
         o_scw[15:gcm_pkg::SIG_USER_LSB] =
            usr[15:gcm_pkg::SIG_USER_LSB];
         o_mcw[gcm_pkg::CW_OPM1:gcm_pkg::CW_OPM0] =
            cw[gcm_pkg::CW_OPM1:gcm_pkg::CW_OPM0];
         o_mcw[gcm_pkg::MC_SYNC] = cw[gcm_pkg::CW_SYNC];
         o_mcw[gcm_pkg::CW_HALT] = cw[gcm_pkg::CW_HALT];
         o_mcw[gcm_pkg::CW_ENA]  = cw[gcm_pkg::CW_ENA] & i_active;
         o_mcw[gcm_pkg::CW_ON]   = cw[gcm_pkg::CW_ON];
         // bits 10 and 11 of the control word reach nothing
      end
   end
endmodule // gcm_ctrl_map
`default_nettype wire

// >>> src/gcm_stat_mem.sv
// per-slave status word table with registered read
`timescale 1ns/1ps
`default_nettype none
module gcm_stat_mem #(
   parameter int W  = 16,
   parameter int AW = 4
) (
   input  wire logic          i_clk_sys,
   input  wire logic          i_reset,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [W-1:0]  i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [W-1:0]  o_rdata
);
   logic [W-1:0] mem [2**AW];
   logic [W-1:0] rdata_q;

   // table contents are not reset; unwritten entries are undefined
   always_ff @(posedge i_clk_sys) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem[i_raddr];
      end
   end

   assign o_rdata = rdata_q;
endmodule // gcm_stat_mem
`default_nettype wire

// >>> src/gcm_mapper.sv
// group master control and status word mapper with register slave
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gcm_mapper #(
   parameter int NUM_SLAVES = 9
) (
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_reset,
   input  wire logic                    i_wb_cyc,
   input  wire logic                    i_wb_stb,
   input  wire logic                    i_wb_we,
   input  wire logic [7:0]              i_wb_adr,
   input  wire logic [3:0]              i_wb_sel,
   input  wire logic [31:0]             i_wb_dat,
   output logic      [31:0]             o_wb_dat,
   output logic                         o_wb_ack,
   input  wire gcm_pkg::gcm_up_t        i_up,
   output gcm_pkg::gcm_dn_t             o_dn,
   input  wire gcm_pkg::gcm_gs_t        i_gs,
   output gcm_pkg::gcm_fs_t             o_fs
);
   localparam int IW = gcm_pkg::IDX_W;
   localparam logic [IW-1:0] LAST_IDX = IW'(NUM_SLAVES - 1);

   logic [3:0]        cfg_q;
   logic [3:0]        cfg_d;
   logic [IW-1:0]     sel_q;
   logic [IW-1:0]     sel_d;
   logic              ack_q;
   logic              ack_d;
   logic [31:0]       rdat_q;
   logic [31:0]       rdat_d;
   logic [15:0]       dn_cnt_q;
   logic [15:0]       dn_cnt_d;
   logic [15:0]       fs_cnt_q;
   logic [15:0]       fs_cnt_d;
   gcm_pkg::gcm_dn_t  dn_q;
   gcm_pkg::gcm_dn_t  dn_d;
   gcm_pkg::gcm_fs_t  fs_q;
   gcm_pkg::gcm_fs_t  fs_d;

   logic              ring;
   logic              reduced;
   logic              active;
   logic              sig_dflt;
   logic              wb_hit;
   logic              up_ok;
   logic              gs_ok;
   logic [31:0]       map_mcw;
   logic [15:0]       map_scw;
   logic [15:0]       built;
   logic [15:0]       tbl_rdata;

   // register slave

   assign ring     = cfg_q[gcm_pkg::CFG_RING_BIT];
   assign reduced  = cfg_q[gcm_pkg::CFG_RED_BIT];
   assign active   = cfg_q[gcm_pkg::CFG_ACT_BIT];
   assign sig_dflt = cfg_q[gcm_pkg::CFG_SIG_BIT];

   // one answer per request; ack drops the cycle after it was given
   assign wb_hit = i_wb_cyc & i_wb_stb & ~ack_q;

   always_comb begin
      cfg_d  = cfg_q;
      sel_d  = sel_q;
      ack_d  = wb_hit;
      rdat_d = 32'h0000_0000;
      if (wb_hit) begin
         case (i_wb_adr)
            gcm_pkg::ADDR_CFG: begin
               rdat_d[3:0] = cfg_q;
               if (i_wb_we && i_wb_sel[0]) begin
                  cfg_d = i_wb_dat[3:0];
               end
            end
            gcm_pkg::ADDR_CNT: begin
               rdat_d = {dn_cnt_q, fs_cnt_q};
            end
            gcm_pkg::ADDR_SEL: begin
               rdat_d[IW-1:0] = sel_q;
               if (i_wb_we && i_wb_sel[0]) begin
                  sel_d = i_wb_dat[IW-1:0];
               end
            end
            gcm_pkg::ADDR_TBL: begin
               // table word trails a select write by one cycle
               rdat_d[15:0] = tbl_rdata;
            end
            default: begin
               rdat_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         cfg_q  <= gcm_pkg::CFG_RST;
         sel_q  <= '0;
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         cfg_q  <= cfg_d;
         sel_q  <= sel_d;
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   // downstream: control word translation

   gcm_ctrl_map u_ctrl_map (
      .i_ctrl    (i_up.ctrl),
      .i_sig     (i_up.sig_ctrl),
      .i_sig_on  (i_up.sig_on),
      .i_mcw     (i_up.mcw),
      .i_ring    (ring),
      .i_reduced (reduced),
      .i_active  (active),
      .o_mcw     (map_mcw),
      .o_scw     (map_scw)
   );

   // out of range slave numbers are dropped silently
   assign up_ok = i_up.valid && (i_up.idx <= LAST_IDX);
   assign gs_ok = i_gs.valid && (i_gs.idx <= LAST_IDX);

   always_comb begin
      dn_d     = '0;
      dn_cnt_d = dn_cnt_q;
      if (up_ok) begin
         // same single-cycle path in every mode, no extra stage
         dn_d.valid  = 1'b1;
         dn_d.idx    = i_up.idx;
         dn_d.mcw    = map_mcw;
         dn_d.scw    = map_scw;
         dn_d.scw_on = sig_dflt;
         dn_d.cmd    = i_up.cmd;
         dn_cnt_d    = dn_cnt_q + 16'h0001;
      end
   end

   // upstream: status word assembly

   always_comb begin
      built = 16'h0000;
      if (ring) begin
         built = i_gs.dsw[15:0];
      end else begin
         built[gcm_pkg::FS_OPACK]  = i_gs.ssw[0];
         built[gcm_pkg::FS_INREF]  = i_gs.ssw[1];
         built[gcm_pkg::FS_STILL]  = i_gs.ssw[2];
         built[gcm_pkg::FS_REACH]  = i_gs.ssw[3];
         built[gcm_pkg::FS_CHG]    = i_gs.dsw[gcm_pkg::DS_CHG];
         built[gcm_pkg::FS_PROC]   = i_gs.dsw[gcm_pkg::DS_PROC];
         built[9:8]                = i_gs.dsw[9:8];
         built[gcm_pkg::FS_CMDACK] = i_gs.ssw[4];
         built[15:11]              = i_gs.dsw[15:11];
      end
   end

   always_comb begin
      fs_d     = '0;
      fs_cnt_d = fs_cnt_q;
      if (gs_ok) begin
         fs_d.valid  = 1'b1;
         fs_d.idx    = i_gs.idx;
         fs_d.stat   = built;
         fs_d.sig_on = sig_dflt;
         fs_d.act    = i_gs.act;
         if (ring) begin
            fs_d.sig_stat = i_gs.ssw;
         end else begin
            fs_d.sig_stat[15:gcm_pkg::SIG_USER_LSB] =
               i_gs.ssw[15:gcm_pkg::SIG_USER_LSB];
         end
         fs_cnt_d = fs_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         dn_q     <= '0;
         fs_q     <= '0;
         dn_cnt_q <= 16'h0000;
         fs_cnt_q <= 16'h0000;
      end else begin
         dn_q     <= dn_d;
         fs_q     <= fs_d;
         dn_cnt_q <= dn_cnt_d;
         fs_cnt_q <= fs_cnt_d;
      end
   end

   assign o_dn = dn_q;
   assign o_fs = fs_q;

   // last status word of each slave, readable by software
   gcm_stat_mem #(
      .W  (16),
      .AW (IW)
   ) u_stat_mem (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_we      (gs_ok),
      .i_waddr   (i_gs.idx),
      .i_wdata   (built),
      .i_raddr   (sel_q),
      .o_rdata   (tbl_rdata)
   );

   // checks

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   logic fld_up;
   logic red_up;
   assign fld_up = up_ok && !ring && !reduced;
   assign red_up = up_ok && !ring && reduced;

   a_dn_same_cycle: assert property (
      up_ok |=> o_dn.valid && o_dn.idx == $past(i_up.idx))
      else $error("downstream word late or wrong slave");
   a_accept_fwd: assert property (
      fld_up |=> o_dn.scw[0] == $past(i_up.ctrl[0]))
      else $error("accept bit not forwarded");
   a_opset_fwd: assert property (
      fld_up |=> o_dn.scw[7] == $past(i_up.ctrl[1])
                 && o_dn.scw[8] != o_dn.scw[7])
      else $error("operation mode setting wrong");
   a_homing_fwd: assert property (
      fld_up |=> o_dn.scw[1] == $past(i_up.ctrl[2]))
      else $error("homing bit wrong");
   a_pos_bits: assert property (
      fld_up |=> o_dn.scw[3:2] == $past(i_up.ctrl[4:3])
                 && o_dn.scw[6:5] == $past(i_up.ctrl[7:6]))
      else $error("positioning bits wrong");
   a_clear_err: assert property (
      fld_up |=> o_dn.scw[4] == $past(i_up.ctrl[5]))
      else $error("clear error bit wrong");
   a_opmode_copy: assert property (
      up_ok && !ring |=> o_dn.mcw[9:8] == $past(i_up.ctrl[9:8]))
      else $error("operation mode bits wrong");
   a_sync_copy: assert property (
      up_ok && !ring |=> o_dn.mcw[10] == $past(i_up.ctrl[12]))
      else $error("sync toggle wrong");
   a_halt_on: assert property (
      up_ok && !ring |=> o_dn.mcw[13] == $past(i_up.ctrl[13])
                         && o_dn.mcw[15] == $past(i_up.ctrl[15]))
      else $error("halt or on bit wrong");
   a_enable_gate: assert property (
      up_ok && !ring |=>
         o_dn.mcw[14] == ($past(i_up.ctrl[14]) && $past(active)))
      else $error("enable bit not gated");
   a_spare_quiet: assert property (
      up_ok && !ring |=> o_dn.mcw[12:11] == 2'h0
                         && o_dn.mcw[7:0] == 8'h00
                         && o_dn.scw[11:9] == 3'h0)
      else $error("spare bits leak");
   a_reduced_mask: assert property (
      red_up |=> o_dn.scw[6:0] == {2'h0, $past(i_up.ctrl[5]), 4'h0})
      else $error("reduced profile leaks bits");
   a_user_bits: assert property (
      up_ok && !ring && !i_up.sig_on |=> o_dn.scw[15:12] == 4'h0)
      else $error("user signal bits without source");
   a_sig_zero: assert property (
      gs_ok && !ring |=> o_fs.valid && o_fs.sig_stat[11:0] == 12'h000)
      else $error("low signal status bits not zero");
   a_sig_dflt: assert property (
      up_ok |=> o_dn.scw_on == $past(sig_dflt))
      else $error("signal word inclusion wrong");
   a_pass_through: assert property (
      (up_ok |=> o_dn.cmd == $past(i_up.cmd))
      and (gs_ok |=> o_fs.act == $past(i_gs.act)))
      else $error("cyclic data altered");
   a_ring_copy: assert property (
      up_ok && ring && i_up.sig_on |=>
         o_dn.mcw == $past(i_up.mcw) && o_dn.scw == $past(i_up.sig_ctrl))
      else $error("ring copy altered");
   a_status_build: assert property (
      gs_ok && !ring |=>
         o_fs.stat[4:1] == $past(i_gs.ssw[3:0])
         && o_fs.stat[10] == $past(i_gs.ssw[4])
         && o_fs.stat[15:11] == $past(i_gs.dsw[15:11])
         && o_fs.stat[0] == 1'b0 && o_fs.stat[6] == 1'b0)
      else $error("status word wrong");
   a_wb_ack_once: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held too long");
   a_wb_answer: assert property (
      i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("register request not answered");
   a_fs_same_cycle: assert property (
      gs_ok |=> o_fs.valid && o_fs.idx == $past(i_gs.idx))
      else $error("status word late or wrong slave");
   // refused words must leave no trace downstream
   a_refused_drop: assert property (
      i_up.valid && !up_ok |=> !o_dn.valid)
      else $error("refused slave word passed on");
   a_ring_status: assert property (
      gs_ok && ring |=> o_fs.stat == $past(i_gs.dsw[15:0])
                        && o_fs.sig_stat == $past(i_gs.ssw))
      else $error("ring status altered");
   a_fs_sig_dflt: assert property (
      gs_ok |=> o_fs.sig_on == $past(sig_dflt))
      else $error("status signal word inclusion wrong");

   c_field_ctrl: cover property (fld_up ##1 o_dn.valid);
   c_reduced: cover property (red_up);
   c_ring: cover property (up_ok && ring);
   c_status: cover property (gs_ok && !ring ##1 o_fs.valid);
   c_wb_read: cover property (o_wb_ack && !i_wb_we);
endmodule // gcm_mapper
`default_nettype wire

// >>> test/gcm_slave_model.sv
// behavioural group slave answering each telegram with its status
`timescale 1ns/1ps
`default_nettype none
module gcm_slave_model (
   input  wire logic             i_clk_sys,
   input  wire logic             i_slow,
   input  wire gcm_pkg::gcm_dn_t i_dn,
   input  wire logic [31:0]      i_dsw,
   input  wire logic [15:0]      i_ssw,
   output var gcm_pkg::gcm_gs_t  o_gs
);
   gcm_pkg::gcm_dn_t p1_q = '0;
   gcm_pkg::gcm_dn_t p2_q = '0;
   gcm_pkg::gcm_dn_t s;
   initial o_gs = '0;
   // slow answers take one cycle more
   assign s = i_slow ? p2_q : p1_q;
   always @(posedge i_clk_sys) begin
      p1_q <= i_dn;
      p2_q <= p1_q;
      // idle lines show the inverse, so a stale copy cannot pass
      if (s.valid === 1'b1)
         o_gs <= {1'b1, s.idx, i_dsw, i_ssw, s.cmd};
      else
         o_gs <= {1'b0, ~o_gs[$bits(o_gs)-2:0]};
   end
endmodule // gcm_slave_model
`default_nettype wire

// >>> test/gcm_mapper_test.sv
// self-checking bench for the group control word mapper
`timescale 1ns/1ps
`default_nettype none
module gcm_mapper_test;
   localparam int NS = 9;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             cyc = 1'b0;
   logic             stb = 1'b0;
   logic             we = 1'b0;
   logic             slow = 1'b0;
   logic             ack;
   logic [7:0]       adr = 8'h00;
   logic [3:0]       sel = 4'h0;
   logic [31:0]      wdat = 32'h0;
   logic [31:0]      dsw = 32'h0;
   logic [15:0]      ssw = 16'h0;
   logic [31:0]      rdat;
   logic [31:0]      rd;
   gcm_pkg::gcm_up_t up = '0;
   gcm_pkg::gcm_dn_t dn;
   gcm_pkg::gcm_gs_t gs;
   gcm_pkg::gcm_fs_t fs;
   int               fail_count = 0;
   int               compares = 0;

   always #25 clk = ~clk;

   gcm_mapper #(.NUM_SLAVES(NS)) gcm_mapper_i (
      .i_clk_sys(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_up(up), .o_dn(dn), .i_gs(gs),
      .o_fs(fs));
   gcm_slave_model gcm_slave_model_i (.i_clk_sys(clk), .i_slow(slow),
      .i_dn(dn), .i_dsw(dsw), .i_ssw(ssw), .o_gs(gs));

   task automatic results;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // classic cycle, request held until ack is seen
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      // ack and read data are taken at the edge that samples ack high
      for (int k = 0; k < 16; k++) begin
         @(posedge clk);
         if (ack === 1'b1) begin
            rd = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
            return;
         end
      end
      chk("wb ack", 1, 0);
      results;
   endtask

   function automatic logic [31:0] e_mcw(logic [3:0] c, logic [15:0] w,
                                         logic [31:0] m);
      logic [31:0] r;
      r = 32'h0;
      if (c[0])
         return m;
      r[9:8] = w[9:8];
      r[10] = w[12];
      r[13] = w[13];
      r[14] = w[14] & c[2];
      r[15] = w[15];
      return r;
   endfunction

   function automatic logic [15:0] e_scw(logic [3:0] c, logic [15:0] w,
                                         logic [15:0] s, logic on);
      logic [15:0] k;
      k = c[1] ? (w & 16'hFF22) : w;
      if (c[0])
         return on ? s : 16'h0000;
      return {on ? s[15:12] : 4'h0, 3'h0, ~k[1], k[1], k[7], k[6],
              k[5], k[4], k[3], k[2], k[0]};
   endfunction

   function automatic logic [31:0] e_stat(logic [3:0] c, logic [31:0] d,
                                          logic [15:0] s);
      if (c[0])
         return {s, d[15:0]};
      return {s[15:12], 12'h000, d[15:11], s[4], d[9:8], d[3], 1'b0,
              d[5], s[3:0], 1'b0};
   endfunction

   // one slave word down, its status back up
   task automatic send(input logic [3:0] c,
                       input logic [gcm_pkg::IDX_W-1:0] i,
                       input logic [15:0] w, input logic on);
      gcm_pkg::gcm_up_t u;
      gcm_pkg::gcm_up_t t;
      u = '{1'b1, i, w, ~w, on, {~w, w}, {w, ~w}};
      t = ~u;
      t.valid = 1'b0;
      @(posedge clk);
      up <= u;
      slow <= i[0];
      dsw <= {16'hFFFF, w};
      ssw <= w;
      @(posedge clk);
      up <= t;
      #1;
      chk("dn valid", 1, dn.valid);
      chk("dn idx", i, dn.idx);
      chk("mcw", e_mcw(c, w, u.mcw), dn.mcw);
      chk("scw", e_scw(c, w, ~w, on), dn.scw);
      chk("scw_on", c[3], dn.scw_on);
      chk("cmd", u.cmd, dn.cmd);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         #1;
         if (fs.valid === 1'b1) begin
            chk("fs idx", i, fs.idx);
            chk("stat", e_stat(c, dsw, ssw), {fs.sig_stat, fs.stat});
            chk("act", u.cmd, fs.act);
            chk("fs sig_on", c[3], fs.sig_on);
            return;
         end
      end
      chk("fs valid", 1, 0);
      results;
   endtask

   // walks a single control bit through every position
   task automatic run_map(input logic [3:0] c);
      wb(1'b1, gcm_pkg::ADDR_CFG, 4'h1, {28'h0, c});
      for (int b = 0; b < 16; b++)
         send(c, 4'(b % NS), 16'h1 << b, b != 3);
   endtask

   // back to back words with a refused slave number between
   task automatic b2b;
      gcm_pkg::gcm_up_t u;
      u = '{1'b1, 4'h0, 16'hC000, 16'h0, 1'b0, 32'h0, 32'h1};
      @(posedge clk);
      up <= u;
      u.idx = 4'(NS);
      @(posedge clk);
      up <= u;
      #1;
      chk("b2b first", 1, dn.valid);
      u.idx = 4'(NS - 1);
      @(posedge clk);
      up <= u;
      #1;
      chk("refused", 0, dn.valid);
      u = ~u;
      u.valid = 1'b0;
      @(posedge clk);
      up <= u;
      #1;
      chk("b2b last", {1'b1, 4'(NS - 1)}, {dn.valid, dn.idx});
      chk("b2b mcw", 32'h8000, dn.mcw);
      repeat (8) @(posedge clk);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("reset outs", 0, {ack, dn.valid, fs.valid});
      wb(1'b0, gcm_pkg::ADDR_CFG, 4'hF, 32'h0);
      chk("cfg reset", 32'h8, rd);
      wb(1'b1, gcm_pkg::ADDR_CFG, 4'hE, 32'h7);
      wb(1'b0, gcm_pkg::ADDR_CFG, 4'hF, 32'h0);
      chk("cfg lanes", 32'h8, rd);
      wb(1'b0, 8'h10, 4'hF, 32'h0);
      chk("unmapped", 32'h0, rd);
      run_map(4'h8);
      run_map(4'hC);
      run_map(4'hE);
      run_map(4'h5);
      wb(1'b1, gcm_pkg::ADDR_CFG, 4'h1, 32'h8);
      b2b;
      wb(1'b0, gcm_pkg::ADDR_CNT, 4'hF, 32'h0);
      chk("counts", {16'h0042, 16'h0042}, rd);
      wb(1'b1, gcm_pkg::ADDR_SEL, 4'h1, 32'h8);
      wb(1'b0, gcm_pkg::ADDR_SEL, 4'hF, 32'h0);
      chk("sel", 32'h8, rd);
      wb(1'b0, gcm_pkg::ADDR_TBL, 4'hF, 32'h0);
      wb(1'b0, gcm_pkg::ADDR_TBL, 4'hF, 32'h0);
      chk("table", e_stat(4'h8, 32'hFFFF8000, 16'h8000) & 32'hFFFF, rd);
      results;
   end
endmodule // gcm_mapper_test
`default_nettype wire
